// ### wsr_map.svh
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
`ifndef WSR_MAP_SVH
`define WSR_MAP_SVH

//------------------------------------------------------------
// Register offsets
//------------------------------------------------------------
`define WSR_ADDR_CONFIG      4'h0
`define WSR_ADDR_STATUS      4'h1
`define WSR_ADDR_PORT        4'h2
`define WSR_ADDR_CMD         4'h3

//------------------------------------------------------------
// Field positions and reset values
//------------------------------------------------------------
`define WSR_CONFIG_RESET     8'hff
`define WSR_ST_PINWAKE       7
`define WSR_ST_TIMEOUT       4
`define WSR_ST_POWERDOWN     3
`define WSR_ST_CORERESET     1
`define WSR_ST_SLEEP         0
`define WSR_CMD_CLEAR        0
`define WSR_CMD_SLEEP        1
`define WSR_PINS_RESET       4'h0

//------------------------------------------------------------
// Timing
//------------------------------------------------------------
`define WSR_CLK_PERIOD_NS    25
`define WSR_T_DRT_LONG_US    18000
`define WSR_T_DRT_SHORT_NS   10000
`define WSR_T_WATCHDOG_US    18000
`define WSR_DRT_SHORT_CYC    (`WSR_T_DRT_SHORT_NS / `WSR_CLK_PERIOD_NS)
`define WSR_DRT_LONG_CYC     (`WSR_T_DRT_LONG_US * 1000 / `WSR_CLK_PERIOD_NS)
`define WSR_WATCHDOG_CYC     (`WSR_T_WATCHDOG_US * 1000 / `WSR_CLK_PERIOD_NS)
`define WSR_CNT_W            20

`endif

// ### wsr_pkg.sv
package wsr_pkg;

  typedef enum logic [2:0] {
    OSC_INTERNAL,
    OSC_EXT_RC,
    OSC_HIGH_SPEED,
    OSC_STANDARD,
    OSC_LOW_POWER,
    OSC_EXT_CLOCK
  } wsr_osc_e;

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_DELAY,
    ST_RUN,
    ST_SLEEP
  } wsr_state_e;

  typedef struct packed {
    logic       wakeChangeDisable;
    logic       pullupDisable;
    logic       timerClockSource;
    logic       timerEdgeSelect;
    logic       prescalerAssign;
    logic [2:0] prescaleSelect;
  } wsr_config_s;

  typedef struct packed {
    logic pinWakeFlag;
    logic timeoutFlagN;
    logic powerdownFlagN;
  } wsr_flags_s;

endpackage

// ### wsr_ctrl.sv
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "wsr_map.svh"

module wsr_ctrl
  import wsr_pkg::*;
#(
  parameter int DRT_LONG_CYC = `WSR_DRT_LONG_CYC,
  parameter int WATCHDOG_CYC = `WSR_WATCHDOG_CYC
) (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  input  wire logic       extResetPinN,
  input  wire logic       extResetEnable,
  input  wire logic       watchdogEnableFuse,
  input  wire wsr_osc_e   oscMode,
  input  wire logic [3:0] wakePins,
  output logic            coreReset,
  output logic            oscEnable,
  output logic            portHold,
  output logic            extResetOut,
  output logic            extResetOe,
  output wsr_flags_s      flags,
  output wsr_config_s     optionCfg
);

  //------------------------------------------------------------
  // Input synchronisers
  //------------------------------------------------------------
  logic [4:0] syncA;
  logic [4:0] syncB;
  logic [4:0] syncC;
  logic [4:0] syncF;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA <= {1'b1, `WSR_PINS_RESET};
      syncB <= {1'b1, `WSR_PINS_RESET};
      syncC <= {1'b1, `WSR_PINS_RESET};
      syncF <= {1'b1, `WSR_PINS_RESET};
    end else begin
      syncA <= {extResetPinN, wakePins};
      syncB <= syncA;
      syncC <= syncB;
      syncF <= (syncB & syncC) | (syncF & (syncB ^ syncC));
    end
  end

  logic       resetPinLow;
  logic [3:0] pinsNow;

  assign resetPinLow = extResetEnable & ~syncF[4];
  assign pinsNow     = syncF[3:0];

  //------------------------------------------------------------
  // Commands and events
  //------------------------------------------------------------
  wsr_state_e state;
  logic       live;
  logic       clearCmd;
  logic       sleepCmd;
  logic       portOp;
  logic [3:0] portLatch;
  logic       watchdogTimeout;
  logic       extResetEvt;
  logic       pinWakeEvt;
  logic       deviceReset;

  // Core is live while running or sleeping
  always_comb begin
    live = 1'b0;
    unique case (state)
      ST_HOLD:  live = 1'b0;
      ST_DELAY: live = 1'b0;
      ST_RUN:   live = 1'b1;
      ST_SLEEP: live = 1'b1;
    endcase
  end

  // Command writes act only while running
  always_comb begin
    clearCmd = 1'b0;
    sleepCmd = 1'b0;
    if (regWr && regAddr == `WSR_ADDR_CMD && state == ST_RUN) begin
      clearCmd = regWdata[`WSR_CMD_CLEAR];
      sleepCmd = regWdata[`WSR_CMD_SLEEP];
    end
  end

  // Any port access refreshes the wake reference
  always_comb begin
    portOp = 1'b0;
    if (regAddr == `WSR_ADDR_PORT) begin
      portOp = regWr || regRd;
    end
  end

  assign extResetEvt = resetPinLow && state != ST_HOLD;
  assign pinWakeEvt  = state == ST_SLEEP && !optionCfg.wakeChangeDisable
                       && (pinsNow != portLatch);
  assign deviceReset = extResetEvt || watchdogTimeout || pinWakeEvt;

  //------------------------------------------------------------
  // Configuration register
  //------------------------------------------------------------
  wsr_config_s optionNext;

  always_comb begin
    optionNext = optionCfg;
    if (deviceReset || state == ST_HOLD) begin
      optionNext = wsr_config_s'(`WSR_CONFIG_RESET);
    end else if (regWr && regAddr == `WSR_ADDR_CONFIG) begin
      optionNext = wsr_config_s'(regWdata);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      optionCfg <= wsr_config_s'(`WSR_CONFIG_RESET);
    end else begin
      optionCfg <= optionNext;
    end
  end

  //------------------------------------------------------------
  // Port latch for wake-on-change
  //------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      portLatch <= `WSR_PINS_RESET;
    end else if (portOp) begin
      portLatch <= pinsNow;
    end
  end

  //------------------------------------------------------------
  // Watchdog counter and prescaler
  //------------------------------------------------------------
  logic [`WSR_CNT_W-1:0] watchdogCnt;
  logic [7:0]            prescaleCnt;
  logic [7:0]            prescaleLast;
  logic                  watchdogTick;
  logic                  watchdogClear;
  logic                  watchdogRun;

  assign prescaleLast  = 8'((9'h001 << optionCfg.prescaleSelect) - 9'h001);
  assign watchdogRun   = watchdogEnableFuse && live;
  assign watchdogTick  = watchdogCnt == `WSR_CNT_W'(WATCHDOG_CYC - 1);
  assign watchdogTimeout = watchdogRun && watchdogTick
                           && (!optionCfg.prescalerAssign || prescaleCnt == prescaleLast);
  assign watchdogClear = clearCmd || sleepCmd || !watchdogRun || deviceReset;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdogCnt <= '0;
    end else if (watchdogClear || watchdogTick) begin
      watchdogCnt <= '0;
    end else begin
      watchdogCnt <= watchdogCnt + `WSR_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      prescaleCnt <= 8'h00;
    end else if (watchdogClear) begin
      prescaleCnt <= 8'h00;
    end else if (watchdogTick && optionCfg.prescalerAssign) begin
      prescaleCnt <= (prescaleCnt == prescaleLast) ? 8'h00 : prescaleCnt + 8'h01;
    end
  end

  //------------------------------------------------------------
  // Start-up delay timer and sequencing
  //------------------------------------------------------------
  logic [`WSR_CNT_W-1:0] delayCnt;
  logic [`WSR_CNT_W-1:0] delayLoad;
  logic                  powerOnPend;
  logic                  crystalMode;

  assign crystalMode = oscMode == OSC_HIGH_SPEED || oscMode == OSC_STANDARD
                       || oscMode == OSC_LOW_POWER;
  assign delayLoad   = (powerOnPend || crystalMode)
                       ? `WSR_CNT_W'(DRT_LONG_CYC - 1)
                       : `WSR_CNT_W'(`WSR_DRT_SHORT_CYC - 1);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_HOLD;
    end else if (extResetEvt) begin
      state <= ST_HOLD;
    end else if (watchdogTimeout || pinWakeEvt) begin
      state <= ST_DELAY;
    end else begin
      unique case (state)
        ST_HOLD:  if (!resetPinLow) state <= ST_DELAY;
        ST_DELAY: if (delayCnt == '0) state <= ST_RUN;
        ST_RUN:   if (sleepCmd) state <= ST_SLEEP;
        ST_SLEEP: state <= ST_SLEEP;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      delayCnt <= '0;
    end else if (state != ST_DELAY || deviceReset) begin
      delayCnt <= delayLoad;
    end else if (delayCnt != '0) begin
      delayCnt <= delayCnt - `WSR_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      powerOnPend <= 1'b1;
    end else if (state == ST_DELAY && delayCnt == '0) begin
      powerOnPend <= 1'b0;
    end
  end

  //------------------------------------------------------------
  // Reset-cause flags
  //------------------------------------------------------------
  wsr_flags_s flagsNext;

  // Event priority: pin reset, watchdog, pin wake, sleep
  always_comb begin
    flagsNext = flags;
    if (extResetEvt) begin
      flagsNext.pinWakeFlag = 1'b0;
      if (state == ST_SLEEP) begin
        flagsNext.timeoutFlagN   = 1'b1;
        flagsNext.powerdownFlagN = 1'b0;
      end
    end else if (watchdogTimeout) begin
      flagsNext.pinWakeFlag  = 1'b0;
      flagsNext.timeoutFlagN = 1'b0;
      if (state == ST_SLEEP) begin
        flagsNext.powerdownFlagN = 1'b0;
      end
    end else if (pinWakeEvt) begin
      flagsNext.pinWakeFlag    = 1'b1;
      flagsNext.timeoutFlagN   = 1'b1;
      flagsNext.powerdownFlagN = 1'b0;
    end else if (sleepCmd) begin
      flagsNext.timeoutFlagN   = 1'b1;
      flagsNext.powerdownFlagN = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flags <= '{pinWakeFlag: 1'b0, timeoutFlagN: 1'b1, powerdownFlagN: 1'b1};
    end else begin
      flags <= flagsNext;
    end
  end

  //------------------------------------------------------------
  // Read port
  //------------------------------------------------------------
  logic [7:0] statusWord;

  always_comb begin
    statusWord = 8'h00;
    statusWord[`WSR_ST_PINWAKE]   = flags.pinWakeFlag;
    statusWord[`WSR_ST_TIMEOUT]   = flags.timeoutFlagN;
    statusWord[`WSR_ST_POWERDOWN] = flags.powerdownFlagN;
    statusWord[`WSR_ST_CORERESET] = !live;
    statusWord[`WSR_ST_SLEEP]     = state == ST_SLEEP;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `WSR_ADDR_STATUS: regRdata <= statusWord;
        `WSR_ADDR_PORT:   regRdata <= {4'h0, pinsNow};
        default:          regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  //------------------------------------------------------------
  // Core and pin control
  //------------------------------------------------------------
  logic sleeping;

  // Asleep from the sleep command until a wake event
  assign sleeping = (state == ST_SLEEP && !deviceReset) || sleepCmd;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      coreReset <= 1'b1;
    end else begin
      coreReset <= !live || deviceReset;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      oscEnable <= 1'b1;
      portHold  <= 1'b0;
    end else begin
      oscEnable <= !sleeping;
      portHold  <= sleeping;
    end
  end

  assign extResetOut = 1'b0;
  assign extResetOe  = 1'b0;

endmodule // wsr_ctrl

// ### wsr_ctrl_properties.sv
`timescale 1ns/1ps
//------------------------------------------------------------
// Checker on the controller ports
//------------------------------------------------------------
module wsr_ctrl_properties
  import wsr_pkg::*;
(
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       extResetPinN,
  input wire logic       watchdogEnableFuse,
  input wire logic       coreReset,
  input wire logic       oscEnable,
  input wire logic       portHold,
  input wire logic       extResetOe,
  input wire wsr_flags_s flags
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_PIN_IDLE: assert property (!extResetOe)
    else $error("reset pin driven");
  AST_PORT_FREEZE: assert property (portHold == !oscEnable)
    else $error("port hold and oscillator disagree");
  AST_SLEEP_ENTRY: assert property (regWr && regAddr == 4'h3 && regWdata[1] && !coreReset && !portHold
    && extResetPinN && $past(extResetPinN, 4) |=> flags.timeoutFlagN && !flags.powerdownFlagN
    ##1 portHold && !oscEnable) else $error("sleep entry wrong");
  AST_FLAG_HOLD: assert property ($changed(flags) |-> ##[0:2] (coreReset || portHold))
    else $error("flags changed without reset");
  AST_RUN_TIMEOUT: assert property ($fell(flags.timeoutFlagN) && !$past(portHold) |->
    !flags.pinWakeFlag && flags.powerdownFlagN == $past(flags.powerdownFlagN)) else $error("run timeout flags");
  AST_SLEEP_TIMEOUT: assert property ($fell(flags.timeoutFlagN) && $past(portHold) |-> flags == 3'b000)
    else $error("sleep timeout flags");
  AST_PIN_WAKE: assert property ($rose(flags.pinWakeFlag) |->
    $past(portHold) && flags.timeoutFlagN && !flags.powerdownFlagN) else $error("pin wake flags");
  AST_WAKE_RESET: assert property ($fell(portHold) |-> ##[0:2] coreReset)
    else $error("wake without core reset");
  AST_NO_WATCHDOG: assert property (!watchdogEnableFuse && !$past(watchdogEnableFuse)
    |-> !$fell(flags.timeoutFlagN)) else $error("disabled watchdog fired");
  AST_WO_READ: assert property (regRd && regAddr == 4'h0 |=> regRdata == 8'h00)
    else $error("config read not zero");
endmodule // wsr_ctrl_properties

// ### wsr_pins_model.sv
`timescale 1ns/1ps
//------------------------------------------------------------
// Reset pin and wake pins
//------------------------------------------------------------
module wsr_pins_model (
  output logic       pinDrive,
  output logic [3:0] wakePins,
  input  wire logic  mclk
);
  initial begin
    pinDrive = 1'b1;
    wakePins = 4'h5;
  end
  // Low pulse, then driven high again
  task automatic pulseReset(input int len);
    @(posedge mclk);
    pinDrive <= 1'b0;
    repeat (len) @(posedge mclk);
    pinDrive <= 1'b1;
  endtask
  task automatic setPins(input logic [3:0] v);
    @(posedge mclk);
    wakePins <= v;
  endtask
endmodule // wsr_pins_model

// ### wsr_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("Error %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
//------------------------------------------------------------
// Testbench
//------------------------------------------------------------
module wsr_ctrl_tb;
  import wsr_pkg::*;
  localparam int STARTUP_DELAY_TIMER = 50;
  localparam int WDC = 20;
  localparam int SHRT = 400;
  logic        mclk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0, extResetEnable = 1'b1, fuse = 1'b1;
  logic [3:0]  regAddr = 4'h0, wakePins;
  logic [7:0]  regWdata = 8'h00, regRdata, d;
  wsr_osc_e    oscMode = OSC_INTERNAL;
  logic        pinDrive, coreReset, oscEnable, portHold, extResetOut, extResetOe;
  wsr_flags_s  flags;
  wsr_config_s cfgOut;
  int          failures = 0, samples_checked = 0, n;
  wire logic   extResetPinN = extResetOe ? extResetOut : pinDrive;
  always #12.5 mclk = ~mclk;
  wsr_pins_model pins (.mclk(mclk), .pinDrive(pinDrive), .wakePins(wakePins));
  wsr_ctrl #(.DRT_LONG_CYC(STARTUP_DELAY_TIMER), .WATCHDOG_CYC(WDC)) dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extResetPinN(extResetPinN),
    .extResetEnable(extResetEnable), .watchdogEnableFuse(fuse), .oscMode(oscMode), .wakePins(wakePins),
    .coreReset(coreReset), .oscEnable(oscEnable), .portHold(portHold), .extResetOut(extResetOut),
    .extResetOe(extResetOe), .flags(flags), .optionCfg(cfgOut));
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 v = regRdata;
    @(posedge mclk);
    #1;
  endtask
  // Cycles until core reset reaches a level
  task automatic waitFor(input logic lvl, input int lim);
    n = 0;
    while (coreReset !== lvl && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask
  task automatic sleepNow(input logic [7:0] cfg);
    wr(4'h0, cfg);
    rd(4'h2, d);
    wr(4'h3, 8'h02);
    @(posedge mclk);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    failures++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1 `CHK("reset flags", 3'b011, flags)
    `CHK("reset config", 8'hFF, cfgOut)
    sys_rst <= 1'b0;
    waitFor(1'b0, 200);
    `CHK("power-on delay", 1'b1, n >= STARTUP_DELAY_TIMER && n <= STARTUP_DELAY_TIMER + 8)
    rd(4'h1, d);
    `CHK("status", 8'h18, d)
    rd(4'h0, d);
    `CHK("config read", 8'h00, d)
    rd(4'hF, d);
    `CHK("unmapped read", 8'h00, d)
    wr(4'h0, 8'h00);
    repeat (6) begin
      wr(4'h3, 8'h01);
      repeat (8) @(posedge mclk);
      #1 `CHK("cleared watchdog", 1'b0, coreReset)
    end
    wr(4'h3, 8'h01);
    waitFor(1'b1, 60);
    `CHK("plain period", 1'b1, n >= WDC - 3 && n <= WDC + 3)
    `CHK("run timeout flags", 3'b001, flags)
    `CHK("config after timeout", 8'hFF, cfgOut)
    waitFor(1'b0, 600);
    `CHK("short delay", 1'b1, n >= SHRT - 2 && n <= SHRT + 8)
    wr(4'h0, 8'h0A);
    wr(4'h3, 8'h01);
    waitFor(1'b1, 200);
    `CHK("prescaled period", 1'b1, n >= 4 * WDC - 5 && n <= 4 * WDC + 3)
    waitFor(1'b0, 600);
    sleepNow(8'h00);
    `CHK("sleep flags", 3'b010, flags)
    `CHK("oscillator off", 1'b0, oscEnable)
    `CHK("ports held", 1'b1, portHold)
    waitFor(1'b1, 60);
    `CHK("sleep period", 1'b1, n >= WDC - 5 && n <= WDC + 2)
    `CHK("watchdog wake flags", 3'b000, flags)
    waitFor(1'b0, 600);
    `CHK("wake delay", 1'b1, n >= SHRT - 2 && n <= SHRT + 8)
    fuse <= 1'b0;
    sleepNow(8'h00);
    repeat (100) @(posedge mclk);
    #1 `CHK("no watchdog wake", 1'b1, portHold)
    pins.setPins(4'h4);
    waitFor(1'b1, 20);
    `CHK("pin wake flags", 3'b110, flags)
    waitFor(1'b0, 600);
    oscMode <= OSC_STANDARD;
    pins.pulseReset(10);
    waitFor(1'b0, 200);
    `CHK("run reset flags", 3'b010, flags)
    `CHK("crystal delay", 1'b1, n >= STARTUP_DELAY_TIMER && n <= STARTUP_DELAY_TIMER + 10)
    sleepNow(8'h80);
    pins.setPins(4'h5);
    repeat (20) @(posedge mclk);
    #1 `CHK("disabled pin wake", 1'b1, portHold)
    pins.pulseReset(10);
    waitFor(1'b0, 200);
    `CHK("sleep reset flags", 3'b010, flags)
    fuse <= 1'b1;
    summarize();
  end
endmodule // wsr_ctrl_tb

bind wsr_ctrl wsr_ctrl_properties props (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extResetPinN(extResetPinN),
  .watchdogEnableFuse(watchdogEnableFuse), .coreReset(coreReset), .oscEnable(oscEnable),
  .portHold(portHold), .extResetOe(extResetOe), .flags(flags));
